// ==== afe_bias_phase_pkg.sv ====
// constants, field layouts and reset values for the input bias and phase block
package afe_bias_phase_pkg;

  // ==========================================================================
  // register byte offsets on the control bus
  localparam logic [7:0] cfg1_offset      = 8'h00;
  localparam logic [7:0] cfg2_offset      = 8'h04;
  localparam logic [7:0] clamp_ref_offset = 8'h08;
  localparam logic [7:0] bias_offset      = 8'h0c;
  localparam logic [7:0] phase_offset     = 8'h10;
  localparam logic [7:0] status_offset    = 8'h14;

  // ==========================================================================
  // field positions
  localparam int follower_bit   = 7;  // main config 1
  localparam int pixel_rate_bit = 2;  // main config 1
  localparam int mode_lsb       = 0;  // main config 1, two bits
  localparam int range_bit      = 4;  // main config 2, 1 = 1.2 V range
  localparam int ref_sel_lsb    = 4;  // clamp reference, two bits
  localparam int dac_code_lsb   = 0;  // clamp reference, four bits
  localparam int cds_bit        = 0;  // bias
  localparam int divider_lsb    = 1;  // bias, three bits r g b
  localparam int clamp_en_bit   = 4;  // bias
  localparam int phase_sel_lsb  = 0;  // phase, two bits
  localparam int clamp_pos_lsb  = 4;  // phase, four bits
  localparam int sample_pos_lsb = 8;  // phase, four bits

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {
    ref_ladder   = 2'b00,
    ref_dac      = 2'b01,
    ref_external = 2'b10,
    ref_spare    = 2'b11
  } ref_sel_type;

  typedef enum logic [1:0] {
    mode_one_a = 2'b00,
    mode_one_b = 2'b01,
    mode_two   = 2'b10,
    mode_three = 2'b11
  } chan_mode_type;

  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  cfg1_reset      = 8'h03;
  localparam logic [7:0]  cfg2_reset      = 8'h00;
  localparam logic [7:0]  clamp_ref_reset = 8'h08;
  localparam logic [7:0]  bias_reset      = 8'h00;
  localparam logic [11:0] phase_reset     = 12'h000;
  localparam int          phase_count     = 4;

endpackage

// ==== afe_input_bias_and_coarse_phase.sv ====
// input bias, clamp reference and coarse pixel phase control with axi4-lite
// Behaviour
// - cds mode switches internal dividers onto chosen red green blue inputs
// - cds mode may instead bias inputs by the clamp pulse method
// - config 1 bit 7 enables source follower on all three inputs
// - config 2 bit 4 zero selects 2.4 V range, gain one
// - clamp reference register chooses one of three pin voltage sources
// - after reset the clamp pin comes from half-supply resistor divider
// - ladder can be disconnected so the pin is driven externally
// - reference select 01 connects the reference dac buffer to the pin
// - dac code is four-bit offset binary, 1000 is mid scale
// - software picks one of four pixel phase clocks shifting sampling
// - default phase zero is aligned with the input clock
// - clamp and sample strobes placed finely inside selected phase
// - device generates sensor drive timing aligned to the input clock
// - config 1 bit 2 marks pixel-rate input, multiplied by channel count
//
// The AXI4-Lite slave port and the address map were left to the implementer.
module afe_input_bias_and_coarse_phase
  import afe_bias_phase_pkg::*;
#(
  parameter int addr_width = 8  // byte address bits decoded
) (
  input  wire logic                  aclk,            // converter-rate clock
  input  wire logic                  aresetn,         // sync reset, low
  input  wire logic [addr_width-1:0] awaddr,          // write address
  input  wire logic                  awvalid,         // write address valid
  output logic                       awready,         // write address ready
  input  wire logic [31:0]           wdata,           // write data
  input  wire logic [3:0]            wstrb,           // write byte lanes
  input  wire logic                  wvalid,          // write data valid
  output logic                       wready,          // write data ready
  output logic [1:0]                 bresp,           // write response
  output logic                       bvalid,          // write response valid
  input  wire logic                  bready,          // write response ready
  input  wire logic [addr_width-1:0] araddr,          // read address
  input  wire logic                  arvalid,         // read address valid
  output logic                       arready,         // read address ready
  output logic [31:0]                rdata,           // read data
  output logic [1:0]                 rresp,           // read response
  output logic                       rvalid,          // read data valid
  input  wire logic                  rready,          // read data ready
  input  wire logic                  clamp_window_in, // optical black window pin
  output logic [2:0]                 follower_enable, // r g b source followers
  output logic [2:0]                 divider_enable,  // r g b bias dividers
  output logic                       gain_two,        // 1.2 V range selected
  output logic                       ladder_connect,  // half-supply ladder on
  output logic                       dac_connect,     // reference dac buffer on
  output logic [3:0]                 dac_code,        // offset binary code
  output logic                       input_clamp_pulse, // input clamp switch
  output logic [3:0]                 coarse_phase_clock, // four phase clocks
  output logic                       clamp_strobe,    // reference-level strobe
  output logic                       sample_strobe,   // signal-level strobe
  output logic                       sensor_drive,    // sensor pixel clock
  output logic [1:0]                 clock_multiplier // 1, 2 or 3
);
  import afe_bias_phase_pkg::*;

  // offsets up to 8'h14 need five bits: a narrower bus could not reach the status register
  if (addr_width < 5 || addr_width > 8) begin
    $error("addr_width must be 5 to 8");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  cfg1, cfg2, clamp_ref, bias, aw_addr;
    logic [11:0] phase;
    logic [3:0]  slot, w_strb, dac_code, coarse_phase_clock;
    logic [1:0]  active_phase, active_mode, bresp, rresp, clock_multiplier;
    logic [31:0] w_data, rdata;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        win_meta, win_sync, run;
    logic [2:0]  follower_enable, divider_enable;
    logic        gain_two, ladder_connect, dac_connect, input_clamp_pulse;
    logic        clamp_strobe, sample_strobe, sensor_drive;
  } state_type;

  state_type st;
  state_type next_st;

  // slots per pixel: four coarse phases of one slot per channel
  function automatic logic [3:0] step_of(input logic [1:0] m);
    step_of = (m == mode_three) ? 4'h3 : (m == mode_two) ? 4'h2 : 4'h1;
  endfunction

  // byte lanes 0 and 1 only; upper lanes hold no register bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = old;
    if (s[0]) merge[7:0] = d[7:0];
    if (s[1]) merge[15:8] = d[15:8];
  endfunction

  logic [3:0]  period, step, start, rel, clamp_pos, sample_pos;
  logic        boundary;
  logic [15:0] wv;
  logic [7:0]  ra;

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_st = st;
    wv = 16'h0000;
    ra = 8'(araddr);

    // axi write: address and data taken in either order
    if (awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_addr = 8'(awaddr);
    end
    if (wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (!st.awready && !st.wready && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = resp_okay;
      if (st.aw_addr == cfg1_offset) begin
        wv = merge({8'h00, st.cfg1}, st.w_data, st.w_strb);
        next_st.cfg1 = wv[7:0];
      end else if (st.aw_addr == cfg2_offset) begin
        wv = merge({8'h00, st.cfg2}, st.w_data, st.w_strb);
        next_st.cfg2 = wv[7:0];
      end else if (st.aw_addr == clamp_ref_offset) begin
        wv = merge({8'h00, st.clamp_ref}, st.w_data, st.w_strb);
        next_st.clamp_ref = wv[7:0];
      end else if (st.aw_addr == bias_offset) begin
        wv = merge({8'h00, st.bias}, st.w_data, st.w_strb);
        next_st.bias = wv[7:0];
      end else if (st.aw_addr == phase_offset) begin
        wv = merge({4'h0, st.phase}, st.w_data, st.w_strb);
        next_st.phase = wv[11:0];
      end else if (st.aw_addr == status_offset) begin
        next_st.bresp = resp_okay;  // read-only, write ignored
      end else begin
        next_st.bresp = resp_slverr;
      end
    end
    if (st.bvalid && bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // axi read: answer one cycle after the address is taken
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = resp_okay;
      if (ra == cfg1_offset) begin
        next_st.rdata = {24'h00_0000, st.cfg1};
      end else if (ra == cfg2_offset) begin
        next_st.rdata = {24'h00_0000, st.cfg2};
      end else if (ra == clamp_ref_offset) begin
        next_st.rdata = {24'h00_0000, st.clamp_ref};
      end else if (ra == bias_offset) begin
        next_st.rdata = {24'h00_0000, st.bias};
      end else if (ra == phase_offset) begin
        next_st.rdata = {20'h0_0000, st.phase};
      end else if (ra == status_offset) begin
        next_st.rdata = {24'h00_0000, st.active_mode, st.active_phase,
                         st.slot};
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = resp_slverr;
      end
    end
    if (st.rvalid && rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // clamp window pin, two-stage synchroniser
    next_st.win_meta = clamp_window_in;
    next_st.win_sync = st.win_meta;
    next_st.run      = 1'b1;  // low until the first edge out of reset

    // pixel slot counter over the active channel mode
    step     = step_of(st.active_mode);
    period   = 4'(step << 2);
    boundary = (st.slot == period - 4'h1);
    next_st.slot = boundary ? 4'h0 : st.slot + 4'h1;
    // phase and mode swap at pixel boundary
    if (boundary) begin
      next_st.active_phase = st.phase[phase_sel_lsb +: 2];
      next_st.active_mode  = st.cfg1[mode_lsb +: 2];
    end

    start = 4'({2'b00, st.active_phase} * step);
    rel   = (st.slot >= start) ? st.slot - start : 4'(st.slot + period - start);
    // phase zero starts at slot zero
    for (int i = 0; i < phase_count; i++) begin
      next_st.coarse_phase_clock[i] =  // five bits: slot + period passes 15
        (5'({1'b0, st.slot} + {1'b0, period} - 5'(i * step))
         % {1'b0, period}) < {1'b0, period >> 1};
    end
    // fine strobe placement, clipped to period
    clamp_pos  = st.phase[clamp_pos_lsb +: 4];
    sample_pos = st.phase[sample_pos_lsb +: 4];
    if (clamp_pos >= period) begin
      clamp_pos = period - 4'h1;
    end
    if (sample_pos >= period) begin
      sample_pos = period - 4'h1;
    end
    next_st.clamp_strobe  = (rel == clamp_pos);
    next_st.sample_strobe = (rel == sample_pos);
    // sensor drive high first half of pixel
    next_st.sensor_drive = (st.slot < (period >> 1));

    // pixel-rate input multiplied by channel count
    next_st.clock_multiplier = st.cfg1[pixel_rate_bit] ? step[1:0] : 2'b01;

    // followers from config 1 bit 7
    next_st.follower_enable = {3{st.cfg1[follower_bit]}};
    // range bit zero gives gain one
    next_st.gain_two = st.cfg2[range_bit];
    next_st.divider_enable = st.bias[cds_bit] ? st.bias[divider_lsb +: 3]
                                              : 3'b000;
    // clamp pulse gated by synced window
    next_st.input_clamp_pulse = st.bias[clamp_en_bit] && st.win_sync;

    // ladder on its own select and on the spare select 11
    next_st.ladder_connect = (st.clamp_ref[ref_sel_lsb +: 2] == ref_ladder) ||
                             (st.clamp_ref[ref_sel_lsb +: 2] == ref_spare);
    next_st.dac_connect = (st.clamp_ref[ref_sel_lsb +: 2] == ref_dac);
    next_st.dac_code = st.clamp_ref[dac_code_lsb +: 4];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.cfg1        <= cfg1_reset;
      st.cfg2        <= cfg2_reset;
      st.clamp_ref   <= clamp_ref_reset;
      st.bias        <= bias_reset;
      st.phase       <= phase_reset;
      st.active_mode <= mode_three;
      st.awready     <= 1'b1;
      st.wready      <= 1'b1;
      st.arready     <= 1'b1;
      st.ladder_connect <= 1'b1;
      st.dac_code    <= 4'h8;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign awready = st.awready;
  assign wready  = st.wready;
  assign bresp   = st.bresp;
  assign bvalid  = st.bvalid;
  assign arready = st.arready;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;
  assign rvalid  = st.rvalid;
  assign follower_enable    = st.follower_enable;
  assign divider_enable     = st.divider_enable;
  assign gain_two           = st.gain_two;
  assign ladder_connect     = st.ladder_connect;
  assign dac_connect        = st.dac_connect;
  assign dac_code           = st.dac_code;
  assign input_clamp_pulse  = st.input_clamp_pulse;
  assign coarse_phase_clock = st.coarse_phase_clock;
  assign clamp_strobe       = st.clamp_strobe;
  assign sample_strobe      = st.sample_strobe;
  assign sensor_drive       = st.sensor_drive;
  assign clock_multiplier   = st.clock_multiplier;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !st.run);  // skip the release edge

  sequence s_write_held;
    !st.awready && !st.wready && !st.bvalid;
  endsequence

  property p_follower;
    ##1 follower_enable == {3{$past(st.cfg1[follower_bit])}};
  endproperty
  a_follower: assert property (p_follower)
    else $error("follower enable does not follow config bit");
  property p_range;
    ##1 gain_two == $past(st.cfg2[range_bit]);
  endproperty
  a_range: assert property (p_range)
    else $error("gain does not follow range bit");
  property p_divider;
    ##1 (divider_enable != 3'b000) |-> $past(st.bias[cds_bit]);
  endproperty
  a_divider: assert property (p_divider)
    else $error("divider enabled outside cds mode");
  property p_dac;
    ##1 dac_connect == ($past(st.clamp_ref[ref_sel_lsb +: 2]) == ref_dac);
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac buffer connect wrong");
  property p_exclusive;
    !(ladder_connect && dac_connect);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("ladder and dac both on the pin");
  property p_phase_boundary;
    $changed(st.active_phase) |-> $past(st.slot == period - 4'h1);
  endproperty
  a_phase_boundary: assert property (p_phase_boundary)
    else $error("phase changed inside a pixel");
  property p_phase_zero;
    (st.slot == 4'h0) |=> coarse_phase_clock[0] && sensor_drive;
  endproperty
  a_phase_zero: assert property (p_phase_zero)
    else $error("phase zero not aligned to pixel start");
  property p_strobe;
    ##1 clamp_strobe == $past(rel == clamp_pos);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("clamp strobe at wrong slot");
  property p_bresp;
    s_write_held |=> bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write not answered");

endmodule

// ==== sensor_model.sv ====
// sensor model: counts drive pixels and raises an optical black window
module sensor_model (
  input  wire logic aclk,            // system clock
  input  wire logic aresetn,         // sync reset, low
  input  wire logic sensor_drive,    // pixel clock from the block
  input  wire logic black_enable,    // bench lets the window run
  output logic      clamp_window_in  // optical black window
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pixel_count;
  logic       drive_last;

  // ==========================================================================
  // pixel counter
  // pixels follow drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pixel_count     <= 4'h0;
      drive_last      <= 1'b0;
      clamp_window_in <= 1'b0;
    end else begin
      drive_last <= sensor_drive;
      if (sensor_drive && !drive_last) begin
        pixel_count <= pixel_count + 4'h1;
      end
      // black pixels only lead the line, so window is short on purpose
      clamp_window_in <= black_enable && (pixel_count < 4'h4);
    end
  end
endmodule

// ==== test_afe_input_bias_and_coarse_phase.sv ====
// self-checking bench for the input bias and coarse phase block
module test_afe_input_bias_and_coarse_phase;
  timeunit 1ns;
  timeprecision 100ps;
  import afe_bias_phase_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, dac_code, coarse_phase_clock, last_cpc;
  logic [1:0] bresp, rresp, clock_multiplier, resp;
  logic awready, wready, bvalid, arready, rvalid, clamp_window_in;
  logic [2:0] follower_enable, divider_enable;
  logic gain_two, ladder_connect, dac_connect, input_clamp_pulse;
  logic clamp_strobe, sample_strobe, sensor_drive, last_drive, black_enable;
  int mismatches, samples_checked, cycles;
  logic [31:0] rd, v;
  int n, k, rp, rc, rs, c, s;

  afe_input_bias_and_coarse_phase uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .clamp_window_in(clamp_window_in),
    .follower_enable(follower_enable), .divider_enable(divider_enable),
    .gain_two(gain_two), .ladder_connect(ladder_connect),
    .dac_connect(dac_connect), .dac_code(dac_code),
    .input_clamp_pulse(input_clamp_pulse),
    .coarse_phase_clock(coarse_phase_clock), .clamp_strobe(clamp_strobe),
    .sample_strobe(sample_strobe), .sensor_drive(sensor_drive),
    .clock_multiplier(clock_multiplier));
  sensor_model sensor (.aclk(aclk), .aresetn(aresetn),
    .sensor_drive(sensor_drive), .black_enable(black_enable),
    .clamp_window_in(clamp_window_in));

  // ==========================================================================
  // clock, history and hang guard
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // previous-cycle copies let rises be seen at the falling edge
  always @(posedge aclk) begin
    last_drive <= sensor_drive;
    last_cpc   <= coarse_phase_clock;
    cycles     <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // master holds each channel until its own ready, waits for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // outputs are registered behind the register: let them land
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, black_enable} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    mismatches = 0; samples_checked = 0; cycles = 0;
    aresetn = 1'b0;
    void'($urandom(25924));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    check("ladder", ladder_connect, 1);
    check("dac code", dac_code, 4'h8);
    check("dac on", dac_connect, 0);
    rd_reg(phase_offset);
    check("phase rst", rd, phase_reset);
    rd_reg(clamp_ref_offset);
    check("ref rst", rd, clamp_ref_reset);
    n = 0;
    repeat (24) begin
      @(negedge aclk);
      n += sensor_drive;
      check("phase0", coarse_phase_clock[0], sensor_drive);
    end
    check("drive duty", n, 12);
    $display("test reset done");
    // followers only together with the 1.2 V range
    for (int i = 0; i < 2; i++) begin
      wr(cfg1_offset, i ? 32'h0000_0083 : 32'h0000_0003);
      wr(cfg2_offset, i << 4);
      settle();
      check("follower", follower_enable, {3{i[0]}});
      check("gain", gain_two, i[0]);
    end
    $display("test follower range done");
    for (int sel = 0; sel < 4; sel++) begin
      v = $urandom & 32'h0000_000f;
      wr(clamp_ref_offset, (sel << 4) | v);
      settle();
      check("ladder", ladder_connect, sel == 0 || sel == 3);
      check("dac on", dac_connect, sel == 1);
      check("code", dac_code, v);
    end
    $display("test clamp reference done");
    repeat (4) begin
      v = $urandom & 32'h0000_000f;
      wr(bias_offset, v);
      settle();
      check("divider", divider_enable, v[0] ? v[3:1] : 3'h0);
    end
    black_enable <= 1'b1;
    for (int e = 1; e >= 0; e--) begin
      wr(bias_offset, e << 4);
      n = 0;
      repeat (400) @(negedge aclk) n += input_clamp_pulse;
      check("clamp pulse", n != 0, e);
    end
    $display("test bias done");
    for (int m = 0; m < 8; m++) begin
      wr(cfg1_offset, m);
      repeat (12) @(posedge aclk);  // mode swaps only at the pixel start
      settle();
      k = (m >= 4 && m[1:0] == 3) ? 3 : (m >= 4 && m[1:0] == 2) ? 2 : 1;
      check("multiplier", clock_multiplier, k);
    end
    $display("test multiplier done");
    wr(cfg1_offset, 32'h0000_0003);
    for (int p = 0; p < 4; p++) begin
      c = $urandom % 12;
      s = $urandom % 12;
      wr(phase_offset, (s << 8) | (c << 4) | p);
      repeat (30) @(posedge aclk);
      rd_reg(status_offset);
      check("active phase", rd[5:4], p);
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (!(sensor_drive && !last_drive) && n < 40);
      rp = -1; rc = -1; rs = -1;
      for (k = 0; k < 24; k++) begin
        if (rp < 0 && coarse_phase_clock[p] && !last_cpc[p]) rp = k;
        if (rp >= 0 && rc < 0 && clamp_strobe) rc = k - rp;
        if (rp >= 0 && rs < 0 && sample_strobe) rs = k - rp;
        @(negedge aclk);
      end
      check("phase shift", rp, p * 3);
      check("clamp pos", rc, c);
      check("sample pos", rs, s);
    end
    $display("test coarse phase done");
    wr(8'h18, 32'h0000_00ff);
    check("bad wr resp", resp, resp_slverr);
    rd_reg(8'h18);
    check("bad rd resp", resp, resp_slverr);
    check("bad rd data", rd, 0);
    wr(status_offset, 32'h0000_0000);
    check("ro wr resp", resp, resp_okay);
    rd_reg(status_offset);
    check("ro mode", rd[7:6], 2'b11);
    $display("test bus errors done");
    conclude();
  end
endmodule
